// ---- cos_converter.sv ----
module cos_converter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Phase in, amplitude code out
    input wire logic [13:0] phase,
    output logic [9:0] code
);

    typedef struct packed {
        logic [9:0] code;
    } state_s;

    state_s st;
    state_s nx;
    logic [13:0] shifted;
    logic [12:0] x;
    logic [26:0] prod;
    logic [9:0] mag;

    // Parabolic cosine: quarter turn ahead, then sign by half
    always_comb begin
        nx = st;
        shifted = phase + dds_pkg::COS_QUARTER;
        x = shifted[12:0];
        prod = 27'(x) * 27'(dds_pkg::COS_HALF - {1'b0, x});
        mag = 10'(prod >> dds_pkg::COS_SHIFT);
        if (mag > dds_pkg::COS_MAG_MAX) begin
            mag = dds_pkg::COS_MAG_MAX;
        end
        if (shifted[13]) begin
            nx.code = dds_pkg::COS_MID_LOW - mag;
        end else begin
            nx.code = dds_pkg::COS_MID + mag;
        end
    end

    // Output register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign code = st.code;

    a_cos_peak: assert property (@(posedge core_clk) disable iff (rst)
        phase == dds_pkg::PHASE_RESET |=> code == dds_pkg::COS_PEAK)
        else $error("zero phase did not give peak code");

endmodule

// ---- dds_host.sv ----
module dds_host (
    // Clock and the settled serial data line
    input wire logic core_clk,
    input wire logic sdio_line,
    // Serial port and strobes towards the core
    output logic cs_n,
    output logic sclk,
    output logic sdio_drv,
    output logic io_update,
    output logic [3:0] profile
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels from time zero
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdio_drv = 1'b0;
        io_update = 1'b0;
        profile = 4'h0;
    end

    // One bit: low phase of three cycles, then a rise held two
    task automatic bit_cycle(input logic b, output logic r);
        sclk <= 1'b0;
        sdio_drv <= b;
        repeat (3) @(posedge core_clk);
        r = sdio_line;
        sclk <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    // Instruction byte then data, MSB first; released line flips each bit
    task automatic xfer(input logic rd, input logic [4:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        logic r;
        logic [7:0] ins;
        n = (addr == 5'h04) ? 32 : ((addr == 5'h05) ? 16 : 8);
        ins = {rd, 2'b00, addr};
        rdata = 32'h0;
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(ins[i], r);
        end
        for (int i = n - 1; i >= 0; i--) begin
            bit_cycle(rd ? ~sdio_drv : wdata[i], r);
            rdata[i] = r;
        end
        cs_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    // Update strobe held two sync periods, then time for the copy
    task automatic strobe();
        io_update <= 1'b1;
        repeat (8) @(posedge core_clk);
        io_update <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask

    // A profile pin change acts as an update
    task automatic toggle_profile(input int k);
        profile[k] <= ~profile[k];
        repeat (12) @(posedge core_clk);
    endtask
endmodule

// ---- dds_pkg.sv ----
package dds_pkg;

    // Channel and datapath widths
    localparam int CHANNELS = 4;
    localparam int ACC_W = 32;
    localparam int PHASE_W = 14;
    localparam int DAC_W = 10;
    localparam int MODE_W = 6;

    // Serial register addresses
    localparam logic [4:0] ADDR_CHAN_SEL = 5'h00;
    localparam logic [4:0] ADDR_RAMP = 5'h01;
    localparam logic [4:0] ADDR_MODE = 5'h03;
    localparam logic [4:0] ADDR_TUNE = 5'h04;
    localparam logic [4:0] ADDR_PHASE = 5'h05;

    // Instruction byte layout
    localparam int INSTR_RD_BIT = 7;
    localparam logic [5:0] INSTR_LAST = 6'h07;

    // Data bits per register access
    localparam logic [5:0] BITS_TUNE = 6'h20;
    localparam logic [5:0] BITS_PHASE = 6'h10;
    localparam logic [5:0] BITS_BYTE = 6'h08;

    // Field positions
    localparam int CHAN_EN_LSB = 4;
    localparam int MODE_SWEEP_BIT = 3;
    localparam int MODE_AMP_BIT = 4;
    localparam int MODE_RAMP_BIT = 5;

    // Reset values
    localparam logic [3:0] CHAN_EN_RESET = 4'hf;
    localparam logic [31:0] TUNE_RESET = 32'h0000_0000;
    localparam logic [13:0] PHASE_RESET = 14'h0000;

    // Sync clock divider: sampled just before its rising edge
    localparam logic [1:0] SYNC_STEP = 2'h1;
    localparam logic [1:0] SYNC_SAMPLE = 2'h1;

    // Channel counts used by the mode checker
    localparam logic [2:0] COUNT_ONE = 3'h1;
    localparam logic [2:0] COUNT_PAIR = 3'h2;

    // Cosine converter constants
    localparam logic [13:0] COS_QUARTER = 14'h1000;
    localparam logic [13:0] COS_HALF = 14'h2000;
    localparam int COS_SHIFT = 15;
    localparam logic [9:0] COS_MID = 10'h200;
    localparam logic [9:0] COS_MID_LOW = 10'h1ff;
    localparam logic [9:0] COS_MAG_MAX = 10'h1ff;
    localparam logic [9:0] COS_PEAK = 10'h3ff;

    typedef enum logic [0:0] {
        SPI_INSTR = 1'b0,
        SPI_DATA = 1'b1
    } spi_state_e;

    typedef enum logic [1:0] {
        RAMP_NONE = 2'b00,
        RAMP_UPPER = 2'b01,
        RAMP_TOP = 2'b10,
        RAMP_SDIO = 2'b11
    } ramp_src_e;

    typedef enum logic [2:0] {
        LVL_NONE = 3'b000,
        LVL_2 = 3'b001,
        LVL_4 = 3'b010,
        LVL_8 = 3'b011,
        LVL_16 = 3'b100
    } mod_level_e;

endpackage

// ---- quad_dds_core.sv ----
// Notes on behaviour
// - Each channel adds its 32-bit tuning word every clock, wrapping.
// - Offset phase maps through cosine to an amplitude sample.
// - A 14-bit phase offset per channel adds before the converter.
// - All four accumulators run on one common clock.
// - Each channel drives a 10-bit converter code every clock.
// - Single-tone, two-level modulation and sweep mix freely.
// - Four-level modulation on at most two channels, rest single-tone.
// - Eight-level modulation on one channel only, rest single-tone.
// - Sixteen-level modulation on one channel only, rest single-tone.
// - Amplitude ramp allowed on all single-tone channels.
// - Ramp on two profile pins: two channels two-level or sweep.
// - Ramp on top profile pin: one eight-level channel.
// - Ramp on spare data lines: four two-level, two four-level, one sixteen.
// - Amplitude modulation excludes the amplitude ramp; sweep does not.
// - Reset gives single-tone, single-bit serial, zero tuning and phase.
// - Tuning and phase addresses shared; writes land in enabled channels.
// - Channel enables act as soon as their byte is written.
// - All channel enables are set at reset.
// - Update starts all channels on new settings together.
// - Rising update strobe, sampled on sync clock, copies buffers.
// - Sync clock runs at a quarter of the core clock.
// - Any profile pin toggle acts as an update strobe.
module quad_dds_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial port, single-bit mode, most significant bit first
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdio_0_in,
    output logic sdio_0_out,
    output logic sdio_0_oe,
    // Update strobe and profile pins
    input wire logic io_update,
    input wire logic [3:0] profile,
    output logic sync_clk,
    // Converter codes and status
    output logic [3:0][9:0] dac_code,
    output logic mode_fault
);

    typedef struct packed {
        logic [1:0] sync_cnt;
        logic upd_q;
        logic [3:0] prof_q;
        logic sclk_q;
        dds_pkg::spi_state_e spi;
        logic [5:0] cnt;
        logic rd;
        logic [4:0] addr;
        logic [31:0] sh;
        logic sdo;
        logic fault;
        logic [3:0] chan_en;
        dds_pkg::ramp_src_e ramp_src;
        logic [3:0][31:0] tune_buf;
        logic [3:0][31:0] tune_act;
        logic [3:0][13:0] phase_buf;
        logic [3:0][13:0] phase_act;
        logic [3:0][5:0] mode_buf;
        logic [3:0][5:0] mode_act;
        logic [3:0][31:0] acc;
    } state_s;

    state_s st;
    state_s nx;
    logic sclk_rise;
    logic sclk_fall;
    logic upd_evt;
    logic wr_commit;
    logic [7:0] instr;
    logic [31:0] wr_data;
    logic [31:0] rd_word;
    logic [1:0] sel;
    logic sel_found;
    logic [3:0][13:0] phase;

    // Data bits carried by an access to a register
    function automatic logic [5:0] data_bits(input logic [4:0] a);
        if (a == dds_pkg::ADDR_TUNE) begin
            return dds_pkg::BITS_TUNE;
        end else if (a == dds_pkg::ADDR_PHASE) begin
            return dds_pkg::BITS_PHASE;
        end else begin
            return dds_pkg::BITS_BYTE;
        end
    endfunction

    // Flags channel mode mixes that the pins cannot serve
    function automatic logic mode_bad(input logic [3:0][5:0] m,
                                      input dds_pkg::ramp_src_e src);
        logic [2:0] n4;
        logic [2:0] n8;
        logic [2:0] n16;
        logic [2:0] nbusy;
        logic [2:0] nr;
        logic [2:0] lvl;
        logic busy;
        logic bad;
        n4 = '0;
        n8 = '0;
        n16 = '0;
        nbusy = '0;
        nr = '0;
        bad = 1'b0;
        for (int i = 0; i < dds_pkg::CHANNELS; i++) begin
            lvl = m[i][2:0];
            busy = (lvl != dds_pkg::LVL_NONE) || m[i][dds_pkg::MODE_SWEEP_BIT];
            n4 = n4 + {2'b00, lvl == dds_pkg::LVL_4};
            n8 = n8 + {2'b00, lvl == dds_pkg::LVL_8};
            n16 = n16 + {2'b00, lvl == dds_pkg::LVL_16};
            nbusy = nbusy + {2'b00, busy};
            // Ramp on single-tone channels never counts against the pins
            nr = nr + {2'b00, busy && m[i][dds_pkg::MODE_RAMP_BIT]};
            if (lvl > dds_pkg::LVL_16) begin
                bad = 1'b1;
            end
            if (m[i][dds_pkg::MODE_AMP_BIT]
                && m[i][dds_pkg::MODE_RAMP_BIT]) begin
                bad = 1'b1;
            end
        end
        // Two-level and sweep alone are always accepted
        if (n4 != '0 && (n4 > dds_pkg::COUNT_PAIR || nbusy != n4)) begin
            bad = 1'b1;
        end
        if (n8 != '0 && nbusy != dds_pkg::COUNT_ONE) begin
            bad = 1'b1;
        end
        if (n16 != '0 && nbusy != dds_pkg::COUNT_ONE) begin
            bad = 1'b1;
        end
        if (nr != '0) begin
            case (src)
                dds_pkg::RAMP_NONE: begin
                    bad = 1'b1;
                end
                dds_pkg::RAMP_UPPER: begin
                    if (nr > dds_pkg::COUNT_PAIR || nbusy != nr
                        || (n4 | n8 | n16) != '0) begin
                        bad = 1'b1;
                    end
                end
                dds_pkg::RAMP_TOP: begin
                    if (n8 != dds_pkg::COUNT_ONE || nbusy != nr) begin
                        bad = 1'b1;
                    end
                end
                default: begin
                    if (n8 != '0) begin
                        bad = 1'b1;
                    end
                end
            endcase
        end
        return bad;
    endfunction

    // Next state: sync divider, serial port, registers, accumulators
    always_comb begin
        nx = st;
        upd_evt = 1'b0;
        wr_commit = 1'b0;
        sclk_rise = sclk && !st.sclk_q;
        sclk_fall = !sclk && st.sclk_q;
        instr = {st.sh[6:0], sdio_0_in};
        wr_data = {st.sh[30:0], sdio_0_in};
        nx.sclk_q = sclk;

        // Sync clock and strobe sampling
        nx.sync_cnt = st.sync_cnt + dds_pkg::SYNC_STEP;
        if (st.sync_cnt == dds_pkg::SYNC_SAMPLE) begin
            nx.upd_q = io_update;
            nx.prof_q = profile;
            upd_evt = (io_update && !st.upd_q)
                      || (profile != st.prof_q);
        end

        // Readback source: lowest enabled channel
        sel = 2'h0;
        sel_found = 1'b0;
        for (int i = dds_pkg::CHANNELS - 1; i >= 0; i--) begin
            if (st.chan_en[i]) begin
                sel = 2'(i);
                sel_found = 1'b1;
            end
        end
        if (instr[4:0] == dds_pkg::ADDR_CHAN_SEL) begin
            rd_word = {st.chan_en, 4'h0, 24'h0};
        end else if (instr[4:0] == dds_pkg::ADDR_RAMP) begin
            rd_word = {st.fault, 5'h0, st.ramp_src, 24'h0};
        end else if (!sel_found) begin
            rd_word = '0;
        end else if (instr[4:0] == dds_pkg::ADDR_MODE) begin
            rd_word = {2'h0, st.mode_buf[sel], 24'h0};
        end else if (instr[4:0] == dds_pkg::ADDR_TUNE) begin
            rd_word = st.tune_buf[sel];
        end else if (instr[4:0] == dds_pkg::ADDR_PHASE) begin
            rd_word = {2'h0, st.phase_buf[sel], 16'h0};
        end else begin
            rd_word = '0;
        end

        // Serial port sequencing
        if (cs_n) begin
            nx.spi = dds_pkg::SPI_INSTR;
            nx.cnt = '0;
            nx.rd = 1'b0;
        end else begin
            if (sclk_rise) begin
                nx.cnt = st.cnt + 6'h01;
                if (!(st.spi == dds_pkg::SPI_DATA && st.rd)) begin
                    nx.sh = wr_data;
                end
                case (st.spi)
                    dds_pkg::SPI_INSTR: begin
                        if (st.cnt == dds_pkg::INSTR_LAST) begin
                            nx.spi = dds_pkg::SPI_DATA;
                            nx.cnt = '0;
                            nx.rd = instr[dds_pkg::INSTR_RD_BIT];
                            nx.addr = instr[4:0];
                            if (instr[dds_pkg::INSTR_RD_BIT]) begin
                                nx.sh = rd_word;
                            end
                        end
                    end
                    dds_pkg::SPI_DATA: begin
                        if (st.cnt == data_bits(st.addr) - 6'h01) begin
                            nx.spi = dds_pkg::SPI_INSTR;
                            nx.cnt = '0;
                            nx.rd = 1'b0;
                            wr_commit = !st.rd;
                        end
                    end
                    default: begin
                        nx.spi = dds_pkg::SPI_INSTR;
                    end
                endcase
            end
            if (sclk_fall && st.spi == dds_pkg::SPI_DATA && st.rd) begin
                nx.sdo = st.sh[31];
                nx.sh = {st.sh[30:0], 1'b0};
            end
        end

        // Register writes
        if (wr_commit) begin
            if (st.addr == dds_pkg::ADDR_CHAN_SEL) begin
                nx.chan_en = wr_data[7:dds_pkg::CHAN_EN_LSB];
            end else if (st.addr == dds_pkg::ADDR_RAMP) begin
                nx.ramp_src = dds_pkg::ramp_src_e'(wr_data[1:0]);
            end else begin
                for (int i = 0; i < dds_pkg::CHANNELS; i++) begin
                    if (st.chan_en[i]) begin
                        if (st.addr == dds_pkg::ADDR_TUNE) begin
                            nx.tune_buf[i] = wr_data;
                        end else if (st.addr == dds_pkg::ADDR_PHASE) begin
                            nx.phase_buf[i] = wr_data[13:0];
                        end else if (st.addr == dds_pkg::ADDR_MODE) begin
                            nx.mode_buf[i] = wr_data[5:0];
                        end
                    end
                end
            end
        end

        // Update moves every buffer at once
        if (upd_evt) begin
            nx.tune_act = st.tune_buf;
            nx.phase_act = st.phase_buf;
            nx.mode_act = st.mode_buf;
        end
        nx.fault = mode_bad(st.mode_act, st.ramp_src);

        // Phase accumulators wrap naturally
        for (int i = 0; i < dds_pkg::CHANNELS; i++) begin
            nx.acc[i] = st.acc[i] + st.tune_act[i];
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.chan_en <= dds_pkg::CHAN_EN_RESET;
        end else begin
            st <= nx;
        end
    end

    // Per channel offset add and cosine converter
    generate
        for (genvar g = 0; g < dds_pkg::CHANNELS; g++) begin : g_chan
            assign phase[g] = st.acc[g][31:18] + st.phase_act[g];
            cos_converter u_cos (
                .core_clk(core_clk),
                .rst(rst),
                .phase(phase[g]),
                .code(dac_code[g])
            );
        end
    endgenerate

    // Pin outputs
    assign sync_clk = st.sync_cnt[1];
    assign sdio_0_out = st.sdo;
    assign sdio_0_oe = !cs_n && st.spi == dds_pkg::SPI_DATA && st.rd;
    assign mode_fault = st.fault;

    a_acc_adds: assert property (@(posedge core_clk) disable iff (rst)
        (!upd_evt ##1 !upd_evt) |=> st.acc[0] ==
            32'($past(st.acc[0], 2) + (st.tune_act[0] << 1)))
        else $error("accumulator did not add tuning word");

    a_reset_enables: assert property (@(posedge core_clk) disable iff (rst)
        $fell(rst) |-> st.chan_en == dds_pkg::CHAN_EN_RESET)
        else $error("channel enables not all set after reset");

    a_reset_clear: assert property (@(posedge core_clk) disable iff (rst)
        $fell(rst) |-> st.tune_act == '0 && st.phase_buf == '0
            && st.mode_act == '0)
        else $error("tuning or phase not cleared by reset");

    a_buf_holds: assert property (@(posedge core_clk) disable iff (rst)
        !upd_evt |=> $stable(st.tune_act) && $stable(st.phase_act))
        else $error("active word changed without update");

    a_update_copy: assert property (@(posedge core_clk) disable iff (rst)
        upd_evt |=> st.tune_act == $past(st.tune_buf)
            && st.phase_act == $past(st.phase_buf))
        else $error("update did not copy buffers");

    a_sync_quarter: assert property (@(posedge core_clk) disable iff (rst)
        $rose(sync_clk) |-> ##4 $rose(sync_clk))
        else $error("sync clock not a quarter of core clock");

    a_profile_toggle: assert property (@(posedge core_clk) disable iff (rst)
        st.sync_cnt == dds_pkg::SYNC_SAMPLE && profile != st.prof_q
            |=> st.tune_act == $past(st.tune_buf))
        else $error("profile toggle missed as update");

    a_enable_immediate: assert property (@(posedge core_clk) disable iff (rst)
        wr_commit && st.addr == dds_pkg::ADDR_CHAN_SEL
            |=> st.chan_en == $past(wr_data[7:4]))
        else $error("channel enables not taken at once");

    a_disabled_keeps: assert property (@(posedge core_clk) disable iff (rst)
        wr_commit && st.addr == dds_pkg::ADDR_PHASE && !st.chan_en[0]
            |=> $stable(st.phase_buf[0]))
        else $error("write reached a disabled channel");

    a_mode_flag: assert property (@(posedge core_clk) disable iff (rst)
        $countones({st.mode_act[0][2:0] == dds_pkg::LVL_8,
                    st.mode_act[1][2:0] == dds_pkg::LVL_8,
                    st.mode_act[2][2:0] == dds_pkg::LVL_8,
                    st.mode_act[3][2:0] == dds_pkg::LVL_8}) > 1
            |=> mode_fault)
        else $error("two eight-level channels not flagged");

endmodule

// ---- quad_dds_core_single_tone_bench.sv ----
module quad_dds_core_single_tone_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic rst;
    logic cs_n;
    logic sclk;
    logic sdio_drv;
    logic sdio_line;
    logic sdio_0_out;
    logic sdio_0_oe;
    logic io_update;
    logic [3:0] profile;
    logic sync_clk;
    logic [3:0][9:0] dac_code;
    logic mode_fault;
    logic [31:0] rd;
    logic [9:0] x0;
    logic [9:0] x2;
    logic prev;
    int num_errors;
    int num_checks;
    int n;

    // Mode mix table: channel mask, mode byte, ramp source, fault
    localparam logic [3:0] MASK[16] = '{4'hf, 4'hf, 4'h3, 4'h7, 4'h1,
        4'h3, 4'h3, 4'hf, 4'h3, 4'h7, 4'h1, 4'hf, 4'h7, 4'h1, 4'h1,
        4'h1};
    localparam logic [7:0] MODE[16] = '{8'h01, 8'h08, 8'h02, 8'h02, 8'h03,
        8'h03, 8'h04, 8'h20, 8'h21, 8'h21, 8'h23, 8'h21, 8'h22, 8'h30,
        8'h21, 8'h05};
    localparam logic [1:0] RSRC[16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h3, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0,
        2'h0};
    localparam logic EXP[16] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
        1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    // Wire level: core drives while its enable is up
    assign sdio_line = sdio_0_oe ? sdio_0_out : sdio_drv;

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    quad_dds_core u_dut (
        .core_clk(core_clk),
        .rst(rst),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdio_0_in(sdio_line),
        .sdio_0_out(sdio_0_out),
        .sdio_0_oe(sdio_0_oe),
        .io_update(io_update),
        .profile(profile),
        .sync_clk(sync_clk),
        .dac_code(dac_code),
        .mode_fault(mode_fault)
    );

    dds_host u_host (
        .core_clk(core_clk),
        .sdio_line(sdio_line),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdio_drv(sdio_drv),
        .io_update(io_update),
        .profile(profile)
    );

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Register write and checked read
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        u_host.xfer(1'b0, a, d, rd);
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        u_host.xfer(1'b1, a, 32'h0, rd);
        check(rd, e);
    endtask

    // Verdict
    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run
    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        end_sim();
    end

    // Test sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        // Reset state: cosine of zero phase on every channel
        for (int i = 0; i < 4; i++) begin
            check(dac_code[i], 10'h3ff);
        end
        check(mode_fault, 1'b0);
        rchk(5'h00, 32'hf0);
        rchk(5'h04, 32'h0);
        rchk(5'h05, 32'h0);
        // Sync clock: two rises in eight cycles
        n = 0;
        prev = sync_clk;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            if (sync_clk && !prev) begin
                n++;
            end
            prev = sync_clk;
        end
        check(n, 2);
        // Per-channel phase through the enables, one update at the end
        wr(5'h00, 32'h10);
        rchk(5'h00, 32'h10);
        wr(5'h05, 32'h2000);
        wr(5'h00, 32'h20);
        wr(5'h05, 32'h0);
        rchk(5'h05, 32'h0);
        wr(5'h00, 32'h10);
        rchk(5'h05, 32'h2000);
        check(dac_code[0], 10'h3ff);
        u_host.strobe();
        check(dac_code[0] < 10'h010, 1'b1);
        check(dac_code[1], 10'h3ff);
        check(dac_code[3], 10'h3ff);
        // Quarter-turn tuning word: period of four, all channels alike
        wr(5'h00, 32'hf0);
        wr(5'h05, 32'h0);
        wr(5'h04, 32'h4000_0000);
        u_host.strobe();
        @(posedge core_clk);
        x0 = dac_code[0];
        check(dac_code[3], x0);
        repeat (2) @(posedge core_clk);
        x2 = dac_code[0];
        check(x2 !== x0, 1'b1);
        repeat (2) @(posedge core_clk);
        check(dac_code[0], x0);
        check(dac_code[2], x0);
        // Zero tuning word applied by a profile pin change freezes output
        wr(5'h04, 32'h0);
        u_host.toggle_profile(2);
        x0 = dac_code[1];
        repeat (3) @(posedge core_clk);
        check(dac_code[1], x0);
        // Mode mixes: clear all modes, then set the table's channels
        for (int i = 0; i < 16; i++) begin
            wr(5'h00, 32'hf0);
            wr(5'h03, 32'h0);
            wr(5'h00, {24'h0, MASK[i], 4'h0});
            wr(5'h03, {24'h0, MODE[i]});
            wr(5'h01, {30'h0, RSRC[i]});
            u_host.strobe();
            check(mode_fault, EXP[i]);
        end
        // Unmapped address ignores writes and reads zero
        wr(5'h02, 32'ha5);
        rchk(5'h02, 32'h0);
        end_sim();
    end
endmodule
